// ===== src/ptc_timer.sv
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
// How it works
// [RULE1] compare A is ten bits, low byte register gives bits 7-0, high register bits 1-0 give 9-8, reset zero.
// [RULE2] compare P is ten bits, split the same way across its low and high registers, reset zero.
// [RULE3] only bits 1-0 of each compare high register exist and bits 7-2 read zero.
// [RULE4] mode 00 is compare-match output, where overflow, an A match or a P match may clear the counter.
// [RULE5] with clear_select low a P match clears the counter (overflow when P is zero) and both flags rise.
// [RULE6] with clear_select high an A match clears the counter and the P flag never rises.
// [RULE7] with compare A zero the counter overflows at 3ff and the A flag does not rise.
// [RULE8] in compare-match mode only an A flag event changes the pin, P events leave it alone.
// [RULE9] an A match drives the pin high, low or toggles it, and an all-zero action leaves it.
// [RULE10] action codes: 00 no change, 01 low, 10 high, 11 toggle.
// [RULE11] a low-to-high change of counter_enable loads the pin with output_level_control.
// [RULE12] mode 11 counts and flags like mode 00 but does not drive the pin.
// [RULE13] software selects PWM with mode 10 and action 10.
// [RULE14] PWM ignores clear_select; one compare sets the period, the other the duty.
// [RULE15] in PWM a P match clears the counter, P zero gives 1024 counts, A at or above the period gives full duty.
// [RULE16] in PWM each comparator raises its own flag on a match.
// [RULE17] in PWM the level bit picks active high or low, the action forces or enables, invert flips the pin.
module ptc_timer
  import ptc_pkg::*;
#(
  parameter int TICK_DIV = PTC_DEF_DIV  // counting clock = ref clock / TICK_DIV
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             tmr_out_o,
  output logic             tmr_out_en_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------------------
  if (TICK_DIV < 1 || TICK_DIV > 65536) begin : g_bad_div
    $error("TICK_DIV must lie in 1..65536");
  end

  localparam int DW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(TICK_DIV - 1);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [DW-1:0]          div;
    logic [PTC_CNT_W-1:0]   cnt;
    logic [PTC_CNT_W-1:0]   cmp_a;
    logic [PTC_CNT_W-1:0]   cmp_p;
    logic                   enable;
    logic [1:0]             mode;
    logic [1:0]             action;
    logic                   level;
    logic                   invert;
    logic                   clr_sel;
    logic [1:0]             flags;
    logic [1:0]             mask;
    logic                   out_lvl;
    logic                   pin;
    logic                   pin_en;
    logic                   irq;
    logic                   ack;
    logic [7:0]             rdat;
  } ptc_state_s;

  ptc_state_s st_ff;
  ptc_state_s nxt_st;

  logic        access;
  logic        wr;
  logic        rd;
  logic        tick;
  logic        run;
  logic        en_rise;
  logic [10:0] cnt_inc;
  logic [10:0] period;
  logic        hit_a;
  logic        hit_p;
  logic        top_a;
  logic        cmp_like;
  logic        clr;
  logic        set_a;
  logic        set_p;
  logic        duty_on;
  logic        pwm_lvl;
  logic        stat_clr;

  // ---------------------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------------------
  // bus qualifiers: one access per request, taken in the cycle before ack
  assign access   = wb_cyc_i & wb_stb_i & ~st_ff.ack;
  assign wr       = access & wb_we_i & wb_sel_i[0];
  assign rd       = access & ~wb_we_i;
  assign stat_clr = rd && (wb_adr_i == PTC_OFF_IRQ_STAT);
  assign en_rise  = wr && (wb_adr_i == PTC_OFF_CTRL0) && wb_dat_i[PTC_BIT_ENABLE] && !st_ff.enable;

  // counting clock enable and comparators
  assign tick     = (st_ff.div == DIV_LAST);
  assign run      = st_ff.enable & tick;
  assign cnt_inc  = {1'b0, st_ff.cnt} + 11'h001;
  assign period   = (st_ff.cmp_p == PTC_RST_CMP) ? PTC_FULL_SPAN : {1'b0, st_ff.cmp_p};  // [RULE15]
  assign hit_p    = (cnt_inc == period);
  assign hit_a    = (st_ff.cmp_a != PTC_RST_CMP) && (cnt_inc == {1'b0, st_ff.cmp_a});  // [RULE7]
  assign top_a    = (st_ff.cmp_a == PTC_RST_CMP) ? (cnt_inc == PTC_FULL_SPAN) : hit_a;  // [RULE7]
  assign cmp_like = (st_ff.mode == PTC_MODE_CMP) || (st_ff.mode == PTC_MODE_TMR);  // [RULE4] [RULE12]
  // clear_select matters only in compare-like modes, PWM always clears on P
  assign clr      = (cmp_like && st_ff.clr_sel) ? top_a : hit_p;  // [RULE5] [RULE6] [RULE14] [RULE15]
  assign set_a    = run & hit_a;  // [RULE5] [RULE16]
  assign set_p    = run & hit_p & ~(cmp_like & st_ff.clr_sel);  // [RULE6] [RULE16]

  // pwm duty: active below compare A, or always when A reaches the period
  assign duty_on  = (st_ff.cnt < st_ff.cmp_a) || ({1'b0, st_ff.cmp_a} >= period);  // [RULE15]
  assign pwm_lvl  = duty_on ? st_ff.level : ~st_ff.level;  // [RULE17]

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // divider for the counting clock
    if (tick) begin
      nxt_st.div = '0;
    end else begin
      nxt_st.div = st_ff.div + DW'(1);
    end

    // counter: zeroed on enable rise, cleared on its match, else counts
    if (en_rise) begin
      nxt_st.cnt = '0;
    end else if (run) begin
      if (clr) begin
        nxt_st.cnt = '0;  // [RULE5] [RULE6] [RULE15]
      end else begin
        nxt_st.cnt = cnt_inc[PTC_CNT_W-1:0];
      end
    end

    // compare-match output latch
    if (en_rise) begin
      nxt_st.out_lvl = st_ff.level;  // [RULE11]
    end else if (st_ff.mode == PTC_MODE_CMP && set_a) begin  // [RULE8]
      case (st_ff.action)  // [RULE9] [RULE10]
        PTC_ACT_LOW:  nxt_st.out_lvl = 1'b0;
        PTC_ACT_HIGH: nxt_st.out_lvl = 1'b1;
        PTC_ACT_TOG:  nxt_st.out_lvl = ~st_ff.out_lvl;
        default:      nxt_st.out_lvl = st_ff.out_lvl;
      endcase
    end

    // pin driver per mode
    case (st_ff.mode)
      PTC_MODE_CMP: begin
        nxt_st.pin    = st_ff.out_lvl ^ st_ff.invert;
        nxt_st.pin_en = 1'b1;
      end
      PTC_MODE_PWM: begin
        case (st_ff.action)  // [RULE17]
          PTC_ACT_NONE: nxt_st.pin = ~st_ff.level ^ st_ff.invert;
          PTC_ACT_LOW:  nxt_st.pin = st_ff.level ^ st_ff.invert;
          PTC_ACT_HIGH: nxt_st.pin = pwm_lvl ^ st_ff.invert;
          default:      nxt_st.pin = ~st_ff.level ^ st_ff.invert;
        endcase
        nxt_st.pin_en = 1'b1;
      end
      default: begin
        nxt_st.pin    = 1'b0;  // [RULE12]
        nxt_st.pin_en = 1'b0;
      end
    endcase

    // sticky flags: a read of status clears, a new event wins
    nxt_st.flags[PTC_BIT_FLAG_A] = set_a | (st_ff.flags[PTC_BIT_FLAG_A] & ~stat_clr);
    nxt_st.flags[PTC_BIT_FLAG_P] = set_p | (st_ff.flags[PTC_BIT_FLAG_P] & ~stat_clr);
    nxt_st.irq = |(nxt_st.flags & st_ff.mask);

    // register writes
    if (wr) begin
      if (wb_adr_i == PTC_OFF_CTRL0) begin
        nxt_st.enable = wb_dat_i[PTC_BIT_ENABLE];
      end else if (wb_adr_i == PTC_OFF_CTRL1) begin
        nxt_st.mode    = wb_dat_i[PTC_BIT_MODE_HI:PTC_BIT_MODE_LO];
        nxt_st.action  = wb_dat_i[PTC_BIT_ACT_HI:PTC_BIT_ACT_LO];
        nxt_st.level   = wb_dat_i[PTC_BIT_LEVEL];
        nxt_st.invert  = wb_dat_i[PTC_BIT_INVERT];
        nxt_st.clr_sel = wb_dat_i[PTC_BIT_CLRSEL];
      end else if (wb_adr_i == PTC_OFF_CMPA_LO) begin
        nxt_st.cmp_a[7:0] = wb_dat_i[7:0];  // [RULE1]
      end else if (wb_adr_i == PTC_OFF_CMPA_HI) begin
        nxt_st.cmp_a[9:8] = wb_dat_i[1:0];  // [RULE1] [RULE3]
      end else if (wb_adr_i == PTC_OFF_CMPP_LO) begin
        nxt_st.cmp_p[7:0] = wb_dat_i[7:0];  // [RULE2]
      end else if (wb_adr_i == PTC_OFF_CMPP_HI) begin
        nxt_st.cmp_p[9:8] = wb_dat_i[1:0];  // [RULE2] [RULE3]
      end else if (wb_adr_i == PTC_OFF_IRQ_MASK) begin
        nxt_st.mask = wb_dat_i[1:0];
      end
    end

    // read data, unmapped reads return zero
    nxt_st.rdat = 8'h00;
    if (rd) begin
      if (wb_adr_i == PTC_OFF_CTRL0) begin
        nxt_st.rdat = {4'h0, st_ff.enable, 3'h0};
      end else if (wb_adr_i == PTC_OFF_CTRL1) begin
        nxt_st.rdat = {st_ff.mode, st_ff.action, st_ff.level, st_ff.invert, 1'b0, st_ff.clr_sel};
      end else if (wb_adr_i == PTC_OFF_CMPA_LO) begin
        nxt_st.rdat = st_ff.cmp_a[7:0];
      end else if (wb_adr_i == PTC_OFF_CMPA_HI) begin
        nxt_st.rdat = {6'h00, st_ff.cmp_a[9:8]};  // [RULE3]
      end else if (wb_adr_i == PTC_OFF_CMPP_LO) begin
        nxt_st.rdat = st_ff.cmp_p[7:0];
      end else if (wb_adr_i == PTC_OFF_CMPP_HI) begin
        nxt_st.rdat = {6'h00, st_ff.cmp_p[9:8]};  // [RULE3]
      end else if (wb_adr_i == PTC_OFF_CNT_LO) begin
        nxt_st.rdat = st_ff.cnt[7:0];
      end else if (wb_adr_i == PTC_OFF_CNT_HI) begin
        nxt_st.rdat = {6'h00, st_ff.cnt[9:8]};
      end else if (wb_adr_i == PTC_OFF_IRQ_STAT) begin
        nxt_st.rdat = {6'h00, st_ff.flags};
      end else if (wb_adr_i == PTC_OFF_IRQ_MASK) begin
        nxt_st.rdat = {6'h00, st_ff.mask};
      end
    end

    // single-cycle ack for every request, mapped or not
    nxt_st.ack = access;
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      st_ff         <= '0;
      st_ff.cmp_a   <= PTC_RST_CMP;
      st_ff.cmp_p   <= PTC_RST_CMP;
      st_ff.mode    <= PTC_RST_CTRL[1:0];
      st_ff.flags   <= PTC_RST_FLAGS;
      st_ff.mask    <= PTC_RST_FLAGS;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs
  assign wb_dat_o     = {24'h000000, st_ff.rdat};
  assign wb_ack_o     = st_ff.ack;
  assign tmr_out_o    = st_ff.pin;
  assign tmr_out_en_o = st_ff.pin_en;
  assign irq_o        = st_ff.irq;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  AST_CMPA_LO_WRITE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)  // [RULE1]
    wr && wb_adr_i == PTC_OFF_CMPA_LO |=> st_ff.cmp_a[7:0] == $past(wb_dat_i[7:0]))
    else $error("compare A low byte not stored");

  AST_CMPP_HI_WRITE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)  // [RULE2]
    wr && wb_adr_i == PTC_OFF_CMPP_HI |=> st_ff.cmp_p[9:8] == $past(wb_dat_i[1:0]))
    else $error("compare P high bits not stored");

  AST_HI_READ_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)  // [RULE3]
    wb_ack_o && !wb_we_i && (wb_adr_i == PTC_OFF_CMPA_HI || wb_adr_i == PTC_OFF_CMPP_HI)
    |-> wb_dat_o[7:2] == 6'h00)
    else $error("compare high register upper bits not zero");

  AST_CLEAR_ON_P: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)  // [RULE5]
    run && !en_rise && cmp_like && !st_ff.clr_sel && hit_p |=> st_ff.cnt == '0 && st_ff.flags[PTC_BIT_FLAG_P])
    else $error("P match did not clear counter and raise P flag");

  AST_CLEAR_ON_A: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)  // [RULE6]
    run && !en_rise && cmp_like && st_ff.clr_sel && hit_a |=> st_ff.cnt == '0)
    else $error("A match did not clear counter");

  AST_NO_P_FLAG: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)  // [RULE6]
    cmp_like && st_ff.clr_sel && !st_ff.flags[PTC_BIT_FLAG_P] |=> !st_ff.flags[PTC_BIT_FLAG_P])
    else $error("P flag raised with clear on A");

  // covers both overflow paths: clear on A with A zero, and clear on P with P zero
  AST_OVERFLOW: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)  // [RULE7]
    run && !en_rise && cmp_like && (st_ff.clr_sel || st_ff.cmp_p == PTC_RST_CMP)
    && st_ff.cmp_a == PTC_RST_CMP && st_ff.cnt == 10'h3ff
    |=> st_ff.cnt == '0 && (!st_ff.flags[PTC_BIT_FLAG_A] || $past(st_ff.flags[PTC_BIT_FLAG_A])))
    else $error("overflow at 3ff wrong");

  AST_PIN_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)  // [RULE8]
    st_ff.mode == PTC_MODE_CMP && !set_a && !en_rise |=> $stable(st_ff.out_lvl))
    else $error("pin level changed without A event");

  AST_TOGGLE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)  // [RULE10]
    st_ff.mode == PTC_MODE_CMP && set_a && !en_rise && st_ff.action == PTC_ACT_TOG
    |=> st_ff.out_lvl != $past(st_ff.out_lvl)
    ##1 ($past(st_ff.mode) != PTC_MODE_CMP || tmr_out_o == ($past(st_ff.out_lvl) ^ $past(st_ff.invert))))
    else $error("toggle action failed");

  AST_INIT_LEVEL: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)  // [RULE11]
    en_rise |=> st_ff.out_lvl == $past(st_ff.level) && st_ff.cnt == '0)
    else $error("enable rise did not load initial level");

  AST_TIMER_NO_PIN: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)  // [RULE12]
    st_ff.mode == PTC_MODE_TMR |=> !tmr_out_en_o)
    else $error("timer mode drives the pin");

  AST_FULL_DUTY: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)  // [RULE15]
    st_ff.mode == PTC_MODE_PWM && st_ff.action == PTC_ACT_HIGH && st_ff.cmp_p != PTC_RST_CMP
    && st_ff.cmp_a >= st_ff.cmp_p |=> tmr_out_o == ($past(st_ff.level) ^ $past(st_ff.invert)))
    else $error("pwm duty not full");

  AST_PWM_FLAGS: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)  // [RULE16]
    st_ff.mode == PTC_MODE_PWM && (set_a || set_p)
    |=> (st_ff.flags[PTC_BIT_FLAG_A] || !$past(set_a)) && (st_ff.flags[PTC_BIT_FLAG_P] || !$past(set_p))
    && irq_o == |(st_ff.flags & $past(st_ff.mask)))
    else $error("pwm match flags not raised");

endmodule : ptc_timer

// ===== shared/ptc_pkg.sv
package ptc_pkg;

  // ---------------------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PTC_OFF_CTRL0    = 8'h00;
  localparam logic [7:0] PTC_OFF_CTRL1    = 8'h04;
  localparam logic [7:0] PTC_OFF_CMPA_LO  = 8'h08;
  localparam logic [7:0] PTC_OFF_CMPA_HI  = 8'h0c;
  localparam logic [7:0] PTC_OFF_CMPP_LO  = 8'h10;
  localparam logic [7:0] PTC_OFF_CMPP_HI  = 8'h14;
  localparam logic [7:0] PTC_OFF_CNT_LO   = 8'h18;
  localparam logic [7:0] PTC_OFF_CNT_HI   = 8'h1c;
  localparam logic [7:0] PTC_OFF_IRQ_STAT = 8'h20;
  localparam logic [7:0] PTC_OFF_IRQ_MASK = 8'h24;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int PTC_BIT_ENABLE  = 3;  // ctrl0: counter_enable
  localparam int PTC_BIT_MODE_HI = 7;  // ctrl1: mode_select_hi
  localparam int PTC_BIT_MODE_LO = 6;  // ctrl1: mode_select_lo
  localparam int PTC_BIT_ACT_HI  = 5;  // ctrl1: output_action_hi
  localparam int PTC_BIT_ACT_LO  = 4;  // ctrl1: output_action_lo
  localparam int PTC_BIT_LEVEL   = 3;  // ctrl1: output_level_control
  localparam int PTC_BIT_INVERT  = 2;  // ctrl1: output_invert
  localparam int PTC_BIT_CLRSEL  = 0;  // ctrl1: clear_select
  localparam int PTC_BIT_FLAG_A  = 0;  // status/mask: match_a_flag
  localparam int PTC_BIT_FLAG_P  = 1;  // status/mask: match_p_flag

  // ---------------------------------------------------------------------------
  // codes, widths and reset values
  // ---------------------------------------------------------------------------
  localparam int          PTC_CNT_W     = 10;
  localparam logic [1:0]  PTC_MODE_CMP  = 2'h0;
  localparam logic [1:0]  PTC_MODE_CAP  = 2'h1;
  localparam logic [1:0]  PTC_MODE_PWM  = 2'h2;
  localparam logic [1:0]  PTC_MODE_TMR  = 2'h3;
  localparam logic [1:0]  PTC_ACT_NONE  = 2'h0;
  localparam logic [1:0]  PTC_ACT_LOW   = 2'h1;
  localparam logic [1:0]  PTC_ACT_HIGH  = 2'h2;
  localparam logic [1:0]  PTC_ACT_TOG   = 2'h3;
  localparam logic [10:0] PTC_FULL_SPAN = 11'h400;  // 1024 counts
  localparam logic [9:0]  PTC_RST_CMP   = 10'h000;
  localparam logic [7:0]  PTC_RST_CTRL  = 8'h00;
  localparam logic [1:0]  PTC_RST_FLAGS = 2'h0;
  localparam int          PTC_DEF_DIV   = 1;

endpackage : ptc_pkg

// ===== tb/ptc_pin_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// pin seen from the board, with a pull-up
// ----------------------------------------
module ptc_pin_model (
  input  wire logic clk_i,
  input  wire logic drv_i,
  input  wire logic drv_en_i,
  output logic      pin_o,
  output int        edges_o,
  output int        high_o,
  output int        low_o
);
  int   run   = 0;
  int   edges = 0;
  int   high  = 0;
  int   low   = 0;
  logic last  = 1'b1;
  // pull-up takes the line high whenever the timer lets go of it
  assign pin_o   = drv_en_i ? drv_i : 1'b1;
  assign edges_o = edges;
  assign high_o  = high;
  assign low_o   = low;
  // width of the last finished high and low phase, in clocks
  always @(posedge clk_i) begin
    if (pin_o !== last) begin
      edges <= edges + 1;
      if (last) begin
        high <= run;
      end else begin
        low <= run;
      end
      run <= 1;
    end else begin
      run <= run + 1;
    end
    last <= pin_o;
  end
endmodule : ptc_pin_model

// ===== tb/ptc_timer_bench.sv
`timescale 1ns/100ps
module ptc_timer_bench
  import ptc_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} ptc_row_s;
  typedef struct packed {logic [1:0] act; logic lvl; logic exp;} ptc_act_s;
  logic        clk   = 1'b0;
  logic        rst_b = 1'b0;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        tout;
  logic        tout_en;
  logic        irq;
  logic        pin;
  logic [7:0]  q;
  int          failures  = 0;
  int          tests_run = 0;
  int          cycles    = 0;
  int          edges;
  int          high_len;
  int          low_len;
  int          e0;
  ptc_row_s    rows [6] = '{'{PTC_OFF_CMPA_LO, 8'hff, 8'hff}, '{PTC_OFF_CMPA_HI, 8'hff, 8'h03},
                            '{PTC_OFF_CMPP_LO, 8'ha5, 8'ha5}, '{PTC_OFF_CMPP_HI, 8'hfe, 8'h02},
                            '{8'h30, 8'h5a, 8'h00}, '{PTC_OFF_IRQ_MASK, 8'h03, 8'h03}};
  ptc_act_s    acts [3] = '{'{PTC_ACT_NONE, 1'b1, 1'b1}, '{PTC_ACT_LOW, 1'b1, 1'b0},
                            '{PTC_ACT_HIGH, 1'b0, 1'b1}};
  // ----------------------------------------
  // clock, design and pin model
  // ----------------------------------------
  always #2.5 clk = ~clk;
  ptc_timer #(.TICK_DIV(1)) ptc_timer_i (
    .ref_clk_i(clk), .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tmr_out_o(tout), .tmr_out_en_o(tout_en), .irq_o(irq));
  ptc_pin_model ptc_pin_model_i (.clk_i(clk), .drv_i(tout), .drv_en_i(tout_en), .pin_o(pin),
    .edges_o(edges), .high_o(high_len), .low_o(low_len));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("Error at %0t: run did not finish", $time);
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // classic cycle: hold until ack is sampled high, take data and release at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string what);
    wb(1'b0, a, 8'h00);
    chk(16'(q), 16'(e), what);
  endtask : rdchk
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  function automatic logic [7:0] ctl(logic [1:0] m, logic [1:0] act, logic lvl, logic inv, logic clr);
    return {m, act, lvl, inv, 1'b0, clr};
  endfunction : ctl
  // stop, program, clear status, then start with an enable rise
  task automatic setup(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p);
    wb(1'b1, PTC_OFF_CTRL0, 8'h00);
    wb(1'b1, PTC_OFF_CTRL1, c1);
    wb(1'b1, PTC_OFF_CMPA_LO, a[7:0]);
    wb(1'b1, PTC_OFF_CMPA_HI, {6'h0, a[9:8]});
    wb(1'b1, PTC_OFF_CMPP_LO, p[7:0]);
    wb(1'b1, PTC_OFF_CMPP_HI, {6'h0, p[9:8]});
    wb(1'b0, PTC_OFF_IRQ_STAT, 8'h00);
    wb(1'b1, PTC_OFF_CTRL0, 8'h08);
  endtask : setup
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      wb(1'b1, rows[k].a, rows[k].d);
      rdchk(rows[k].a, rows[k].e, "register readback");
    end
    $display("test registers done");
    wb(1'b1, PTC_OFF_IRQ_MASK, 8'h00);
    setup(ctl(PTC_MODE_CMP, PTC_ACT_TOG, 1'b0, 1'b0, 1'b0), 10'h003, 10'h008);
    idle(3);
    chk(16'(pin), 16'h0000, "initial level");
    chk(16'(tout_en), 16'h0001, "pin driven");
    idle(40);
    chk(16'(high_len), 16'h0008, "period on P");
    rdchk(PTC_OFF_IRQ_STAT, 8'h03, "flags A and P");
    setup(ctl(PTC_MODE_CMP, PTC_ACT_TOG, 1'b1, 1'b0, 1'b1), 10'h005, 10'h002);
    idle(3);
    chk(16'(pin), 16'h0001, "initial level");
    idle(30);
    chk(16'(low_len), 16'h0005, "period on A");
    rdchk(PTC_OFF_IRQ_STAT, 8'h01, "only A flag");
    $display("test clear select done");
    for (int k = 0; k < 3; k++) begin
      setup(ctl(PTC_MODE_CMP, acts[k].act, acts[k].lvl, 1'b0, 1'b0), 10'h00c, 10'h000);
      idle(3);
      chk(16'(pin), 16'(acts[k].lvl), "initial level");
      idle(20);
      chk(16'(pin), 16'(acts[k].exp), "match action");
    end
    $display("test actions done");
    setup(ctl(PTC_MODE_CMP, PTC_ACT_TOG, 1'b0, 1'b0, 1'b0), 10'h000, 10'h000);
    idle(3);
    e0 = edges;
    idle(2100);
    chk(16'(edges - e0), 16'h0000, "no A match at zero");
    chk(16'(irq), 16'h0000, "masked irq");
    wb(1'b1, PTC_OFF_IRQ_MASK, 8'h02);
    idle(2);
    chk(16'(irq), 16'h0001, "unmasked irq");
    rdchk(PTC_OFF_IRQ_STAT, 8'h02, "overflow flags");
    idle(2);
    chk(16'(irq), 16'h0000, "irq after read");
    wb(1'b1, PTC_OFF_IRQ_MASK, 8'h00);
    $display("test overflow done");
    setup(ctl(PTC_MODE_TMR, PTC_ACT_TOG, 1'b0, 1'b0, 1'b0), 10'h003, 10'h008);
    idle(20);
    chk(16'(tout_en), 16'h0000, "pin released");
    rdchk(PTC_OFF_IRQ_STAT, 8'h03, "timer flags");
    $display("test timer mode done");
    setup(ctl(PTC_MODE_PWM, PTC_ACT_HIGH, 1'b1, 1'b0, 1'b1), 10'h003, 10'h00a);
    idle(50);
    chk(16'(high_len), 16'h0003, "pwm duty");
    chk(16'(low_len), 16'h0007, "pwm rest");
    rdchk(PTC_OFF_IRQ_STAT, 8'h03, "pwm flags");
    setup(ctl(PTC_MODE_PWM, PTC_ACT_HIGH, 1'b1, 1'b1, 1'b0), 10'h003, 10'h00a);
    idle(50);
    chk(16'(high_len), 16'h0007, "inverted duty");
    setup(ctl(PTC_MODE_PWM, PTC_ACT_NONE, 1'b1, 1'b0, 1'b0), 10'h003, 10'h00a);
    idle(30);
    chk(16'(pin), 16'h0000, "forced inactive");
    setup(ctl(PTC_MODE_PWM, PTC_ACT_LOW, 1'b1, 1'b0, 1'b0), 10'h003, 10'h00a);
    idle(30);
    chk(16'(pin), 16'h0001, "forced active");
    setup(ctl(PTC_MODE_PWM, PTC_ACT_TOG, 1'b1, 1'b0, 1'b0), 10'h003, 10'h00a);
    idle(30);
    chk(16'(pin), 16'h0000, "unbuilt pulse code inactive");
    setup(ctl(PTC_MODE_PWM, PTC_ACT_HIGH, 1'b1, 1'b0, 1'b0), 10'h00c, 10'h00a);
    idle(5);
    e0 = edges;
    idle(40);
    chk(16'(edges - e0), 16'h0000, "full duty");
    setup(ctl(PTC_MODE_PWM, PTC_ACT_HIGH, 1'b1, 1'b0, 1'b0), 10'h3e8, 10'h000);
    idle(2100);
    chk(16'(low_len), 16'h0018, "1024 count period");
    $display("test pwm done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      rdchk(PTC_OFF_CMPA_LO + 8'(4 * k), 8'h00, "compare reset");
    end
    chk(16'(irq), 16'h0000, "irq reset");
    $display("test reset done");
    stop_test();
  end
endmodule : ptc_timer_bench
